//--- rtl/dspg_pkg.sv
// What this block does
// - Read overflow at 0x1FF/0x3FF, underflow at 0x001/0x200: keep page, clear EA15.
// - Read overflow 0x2FF goes to 0x300, underflow 0x300 to 0x2FF, EA15 set.
// - Write overflow at page 0x1FF keeps the page and clears EA15.
// - Paged upper-half access with a page register at 0x000 raises a trap.
// - Program space is read-only; pointing the write page at it traps.
// - Large-offset modification gets no pseudolinear page crossing.
// - Base addresses below the upper half always reach page 0.
// - Both page registers reset to 0x001.
// - Software writing zero to a page register is ignored.
// - Non-zero pages are reached only with EA15 set plus a page register.
// - Page n maps the upper half to extended range n times 32 Kbytes.
// - Stack pointer bit 0 always reads zero.
// - Stack pointer resets to 0x1000.
// - Stack grows upward; push writes then increments, pop decrements then reads.
// - PC push stores bits 15:0 first, then 22:16; calls zero the upper byte.
// - Exception entry puts the status low byte beside the upper PC bits.
// - Stack pointer, and frame pointer while frame flag set, are never paged.
// - Upper-half address is page bits 8:0 joined to EA bits 14:0.
// - Other modified-indirect overflows increment the page; underflows decrement, except a write underflow at 0x001, which keeps the page.
// - Offset, modulo and bit-reversed crossings set EA15 and keep the page.
package dspg_pkg;
   localparam logic [9:0] PG_ZERO = 10'h000;
   localparam logic [9:0] PG_RESET = 10'h001;
   localparam logic [9:0] PG_ONE = 10'h001;
   localparam logic [9:0] PG_EDS_LAST = 10'h1ff;
   localparam logic [9:0] PG_LSW_FIRST = 10'h200;
   localparam logic [9:0] PG_LSW_LAST = 10'h2ff;
   localparam logic [9:0] PG_MSB_FIRST = 10'h300;
   localparam logic [9:0] PG_MSB_LAST = 10'h3ff;
   localparam int PG_PS_BIT = 9;
   localparam int EA_HI_BIT = 15;
   localparam logic [7:0] BASE_PAGE_HI = 8'h00;
   localparam logic [15:0] SP_RESET = 16'h1000;
   localparam logic [14:0] SP_STEP = 15'h0001;
   localparam logic [7:0] OFS_RD_PAGE = 8'h00;
   localparam logic [7:0] OFS_WR_PAGE = 8'h04;
   localparam logic [7:0] OFS_SP = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0c;
   localparam int ST_TRAP_PG0 = 0;
   localparam int ST_TRAP_PSW = 1;
   localparam int ST_PSV = 2;
   localparam logic HRESP_OKAY = 1'b0;
   typedef enum logic [1:0] {AM_PLAIN = 2'h0, AM_MODIND = 2'h1, AM_WRAP = 2'h2} dspg_amode_t;
   typedef enum logic [2:0] {
      SC_NONE = 3'h0, SC_PUSH = 3'h1, SC_POP = 3'h2, SC_CALL = 3'h3, SC_EXC = 3'h4
   } dspg_scmd_t;
   typedef struct packed {
      logic valid;
      logic write;
      dspg_amode_t mode;
      logic pre_mod;
      logic inc;
      logic ptr_sp;
      logic ptr_fp;
      logic frame_act;
      logic [15:0] ea_old;
      logic [15:0] ea_new;
   } dspg_acc_req_t;
   typedef struct packed {
      logic valid;
      logic program_space_view;
      logic trap;
      logic [23:0] addr;
      logic [15:0] ea_fix;
   } dspg_acc_res_t;
   typedef struct packed {
      logic we;
      logic re;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dspg_stk_bus_t;
   typedef struct packed {
      logic [9:0] page;
      logic hi;
   } dspg_cross_t;
endpackage

//--- rtl/dspg_stack.sv
`timescale 1ns/1ns
module dspg_stack import dspg_pkg::*; (
   input wire logic clk_sys_i, // System clock.
   input wire logic rst_b_i, // Asynchronous reset, active low.
   input wire dspg_scmd_t cmd_i, // Stack command.
   input wire logic [15:0] wdata_i, // Word to push.
   input wire logic [22:0] pc_i, // Program counter to push.
   input wire logic [7:0] srl_i, // Status low byte.
   input wire logic sw_we_i, // Software write of the pointer.
   input wire logic [15:0] sw_data_i, // Software pointer value.
   output logic [15:0] sp_o, // Stack pointer value.
   output dspg_stk_bus_t bus_o, // Stack memory access.
   output logic busy_o // Second PC word pending.
);
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_PC_HI = 2'b10} dspg_sst_t;
   dspg_sst_t state;
   dspg_sst_t next_state;
   logic [14:0] sp_word;
   logic [14:0] next_sp_word;
   logic [15:0] hi_word;
   dspg_stk_bus_t next_bus;
   wire idle = (state == ST_IDLE);
   wire is_pc = idle && (cmd_i == SC_CALL || cmd_i == SC_EXC);
   wire [14:0] sp_inc = sp_word + SP_STEP;
   wire [14:0] sp_dec = sp_word - SP_STEP;
   // Only bits 15:1 are stored, so a misaligned pointer cannot exist.
   assign sp_o = {sp_word, 1'b0};
   assign busy_o = !idle;
   ////////////////////////////////////////////////////////////////////////////////
   // Next state, pointer and bus word; a stack operation wins over software.
   always_comb begin
      next_state = state;
      next_sp_word = sp_word;
      next_bus = '0;
      if (sw_we_i) begin
         next_sp_word = sw_data_i[15:1];
      end
      case (state)
         ST_IDLE: begin
            if (cmd_i == SC_PUSH || is_pc) begin
               next_bus.we = 1'b1;
               next_bus.addr = {sp_word, 1'b0};
               next_bus.wdata = is_pc ? pc_i[15:0] : wdata_i;
               next_sp_word = sp_inc;
               next_state = is_pc ? ST_PC_HI : ST_IDLE;
            end else if (cmd_i == SC_POP) begin
               next_bus.re = 1'b1;
               next_bus.addr = {sp_dec, 1'b0};
               next_sp_word = sp_dec;
            end
         end
         ST_PC_HI: begin
            next_bus.we = 1'b1;
            next_bus.addr = {sp_word, 1'b0};
            next_bus.wdata = hi_word;
            next_sp_word = sp_inc;
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end
   // Pointer, state and the upper PC word kept for the second cycle.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= ST_IDLE;
         sp_word <= SP_RESET[15:1];
         bus_o <= '0;
         hi_word <= '0;
      end else begin
         state <= next_state;
         sp_word <= next_sp_word;
         bus_o <= next_bus;
         if (is_pc) begin
            hi_word <= {(cmd_i == SC_EXC) ? srl_i : BASE_PAGE_HI, 1'b0, pc_i[22:16]};
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   a_push_order: assert property (
      idle && cmd_i == SC_PUSH |=> bus_o.we && bus_o.addr == $past(sp_o) && sp_o == $past(sp_o) + 16'h0002)
      else $error("push did not write then increment");
   a_pop_order: assert property (
      idle && cmd_i == SC_POP |=> bus_o.re && bus_o.addr == sp_o && sp_o == $past(sp_o) - 16'h0002)
      else $error("pop did not decrement then read");
   a_call_upper_zero: assert property (
      idle && cmd_i == SC_CALL |=> bus_o.wdata == $past(pc_i[15:0]) ##1
      bus_o.we && bus_o.wdata[15:8] == 8'h00)
      else $error("call push order or zero extension wrong");
   a_exc_status_byte: assert property (
      idle && cmd_i == SC_EXC |=> ##1 bus_o.wdata[15:8] == $past(srl_i, 2))
      else $error("exception push lost status low byte");
endmodule

//--- rtl/dspg_top.sv
`timescale 1ns/1ns
module dspg_top import dspg_pkg::*; (
   input wire logic clk_sys_i, // System clock, 100 MHz.
   input wire logic rst_b_i, // Asynchronous reset, active low.
   input wire logic hsel_i, // AHB slave select.
   input wire logic [31:0] haddr_i, // AHB address.
   input wire logic [1:0] htrans_i, // AHB transfer type.
   input wire logic hwrite_i, // AHB write.
   input wire logic [2:0] hsize_i, // AHB size.
   input wire logic [31:0] hwdata_i, // AHB write data.
   input wire logic hready_i, // AHB ready in.
   output logic hreadyout_o, // AHB ready out.
   output logic hresp_o, // AHB response.
   output logic [31:0] hrdata_o, // AHB read data.
   input wire dspg_acc_req_t acc_i, // Data access from address generation.
   output dspg_acc_res_t res_o, // Translated access.
   output logic trap_o, // Address error trap pulse.
   input wire dspg_scmd_t stk_cmd_i, // Stack command.
   input wire logic [15:0] stk_wdata_i, // Word to push.
   input wire logic [22:0] pc_i, // Program counter.
   input wire logic [7:0] srl_i, // Status low byte.
   output dspg_stk_bus_t stk_bus_o, // Stack memory access.
   output logic stk_busy_o, // Stack busy with PC high word.
   output logic [15:0] stk_ptr_o // Stack pointer value.
);
   ////////////////////////////////////////////////////////////////////////////////
   // Boundary handling for one page register on a modified-indirect crossing.
   // The special pages stop the linear walk at the edges of the extended and
   // program views, because the next page over belongs to another space.
   function automatic dspg_cross_t cross_page(input logic [9:0] pg, input logic ovf,
                                              input logic wr);
      dspg_cross_t r;
      r.page = pg;
      r.hi = 1'b1;
      if (ovf) begin
         if (pg == PG_EDS_LAST || (!wr && pg == PG_MSB_LAST)) begin
            r.hi = 1'b0;
         end else if (!wr && pg == PG_LSW_LAST) begin
            r.page = PG_MSB_FIRST;
         end else begin
            r.page = pg + PG_ONE;
         end
      end else begin
         if (pg == PG_RESET || (!wr && pg == PG_LSW_FIRST)) begin
            r.hi = 1'b0;
         end else if (!wr && pg == PG_MSB_FIRST) begin
            r.page = PG_LSW_LAST;
         end else begin
            r.page = pg - PG_ONE;
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Page registers, status flags and bus data-phase state.
   logic [9:0] rd_page;
   logic [8:0] wr_page;
   logic trap_pg0;
   logic trap_psw;
   logic last_psv;
   logic dp_wr;
   logic dp_rd;
   logic [7:0] dp_addr;
   dspg_acc_res_t next_res;
   logic psw_pulse;

   ////////////////////////////////////////////////////////////////////////////////
   // Pointer classification. The stack pointer and an active frame pointer
   // skip paging so the stack stays coherent in the base 64 Kbytes.
   wire paged_ptr = !(acc_i.ptr_sp || (acc_i.ptr_fp && acc_i.frame_act));
   wire [9:0] wr_page_x = {1'b0, wr_page};
   wire [9:0] pg_cur = acc_i.write ? wr_page_x : rd_page;
   wire crossed = acc_i.ea_old[EA_HI_BIT] && !acc_i.ea_new[EA_HI_BIT];
   wire hw_valid = acc_i.valid && paged_ptr && crossed;
   // Large literal offsets arrive as plain mode, so they never walk pages.
   wire do_step = hw_valid && acc_i.mode == AM_MODIND;
   wire do_wrap = hw_valid && acc_i.mode == AM_WRAP;

   // Both registers are evaluated; only the one of the access direction moves.
   wire dspg_cross_t rd_x = cross_page(rd_page, acc_i.inc, 1'b0);
   wire dspg_cross_t wr_x = cross_page(wr_page_x, acc_i.inc, 1'b1);
   wire dspg_cross_t cur_x = acc_i.write ? wr_x : rd_x;

   ////////////////////////////////////////////////////////////////////////////////
   // Corrected pointer value and the address actually used.
   wire [15:0] ea_mod = (acc_i.mode == AM_PLAIN) ? acc_i.ea_old : acc_i.ea_new;
   wire [15:0] ea_fix = do_step ? {cur_x.hi, acc_i.ea_new[14:0]} :
                        do_wrap ? {1'b1, acc_i.ea_new[14:0]} :
                        ea_mod;
   // Pre-modified accesses use the new page and pointer; post-modified the old.
   wire use_new = acc_i.pre_mod && acc_i.mode != AM_PLAIN;
   wire [15:0] ea_acc = use_new ? ea_fix : acc_i.ea_old;
   wire [9:0] pg_use = (use_new && do_step) ? cur_x.page : pg_cur;
   wire upper = ea_acc[EA_HI_BIT] && paged_ptr;
   wire [23:0] addr_base = {BASE_PAGE_HI, ea_acc};
   wire [23:0] addr_page = {pg_use[8:0], ea_acc[14:0]};
   wire acc_trap = acc_i.valid && upper && pg_use == PG_ZERO;

   ////////////////////////////////////////////////////////////////////////////////
   // Result word, registered so address and trap leave flops together.
   always_comb begin
      next_res = '0;
      next_res.valid = acc_i.valid;
      next_res.ea_fix = ea_fix;
      next_res.addr = upper ? addr_page : addr_base;
      next_res.program_space_view = upper && !acc_i.write && pg_use[PG_PS_BIT];
      next_res.trap = acc_trap;
      if (!acc_i.valid) begin
         next_res.addr = '0;
         next_res.ea_fix = '0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         res_o <= '0;
      end else begin
         res_o <= next_res;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, always OKAY, unmapped reads give zero.
   wire ap_take = hsel_i && htrans_i[1] && hready_i;
   wire sel_rd_page = dp_wr && dp_addr == OFS_RD_PAGE;
   wire sel_wr_page = dp_wr && dp_addr == OFS_WR_PAGE;
   wire sel_sp = dp_wr && dp_addr == OFS_SP;
   wire sel_stat = dp_wr && dp_addr == OFS_STAT;
   // Zero is never stored, so page 0 stays out of reach of the upper half.
   wire sw_rd_ok = sel_rd_page && hwdata_i[9:0] != PG_ZERO;
   // The write page covers data space only; bit 9 would name program space.
   wire sw_psw = sel_wr_page && hwdata_i[PG_PS_BIT];
   wire sw_wr_ok = sel_wr_page && !hwdata_i[PG_PS_BIT] &&
                   hwdata_i[8:0] != PG_ZERO[8:0];
   wire [31:0] stat_word = {29'h0, last_psv, trap_psw, trap_pg0};
   wire [31:0] rd_mux = (dp_addr == OFS_RD_PAGE) ? {22'h0, rd_page} :
                        (dp_addr == OFS_WR_PAGE) ? {23'h0, wr_page} :
                        (dp_addr == OFS_SP) ? {16'h0, stk_ptr_o} :
                        (dp_addr == OFS_STAT) ? stat_word : 32'h0;
   assign hreadyout_o = 1'b1;
   assign hresp_o = HRESP_OKAY;
   assign hrdata_o = dp_rd ? rd_mux : 32'h0;
   assign trap_o = res_o.trap || psw_pulse;

   // Data phase bookkeeping; the size is not checked, only whole words are used.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         dp_addr <= '0;
      end else if (hready_i) begin
         dp_wr <= ap_take && hwrite_i;
         dp_rd <= ap_take && !hwrite_i;
         dp_addr <= haddr_i[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Page registers. A hardware crossing in the same cycle as a software write
   // wins, since the pointer register moves with it and must stay consistent.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_page <= PG_RESET;
      end else if (do_step && !acc_i.write) begin
         rd_page <= rd_x.page;
      end else if (sw_rd_ok) begin
         rd_page <= hwdata_i[9:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_page <= PG_RESET[8:0];
      end else if (do_step && acc_i.write) begin
         wr_page <= wr_x.page[8:0];
      end else if (sw_wr_ok) begin
         wr_page <= hwdata_i[8:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky trap flags, write one to clear; a new trap beats the clear.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         trap_pg0 <= 1'b0;
         trap_psw <= 1'b0;
         last_psv <= 1'b0;
         psw_pulse <= 1'b0;
      end else begin
         psw_pulse <= sw_psw;
         trap_pg0 <= acc_trap || (trap_pg0 && !(sel_stat && hwdata_i[ST_TRAP_PG0]));
         trap_psw <= sw_psw || (trap_psw && !(sel_stat && hwdata_i[ST_TRAP_PSW]));
         if (acc_i.valid) begin
            last_psv <= next_res.program_space_view;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Software stack; its addresses are 16-bit and bypass the page registers.
   dspg_stack u_stack (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .cmd_i(stk_cmd_i),
      .wdata_i(stk_wdata_i),
      .pc_i(pc_i),
      .srl_i(srl_i),
      .sw_we_i(sel_sp),
      .sw_data_i(hwdata_i[15:0]),
      .sp_o(stk_ptr_o),
      .bus_o(stk_bus_o),
      .busy_o(stk_busy_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   wire rd_step = do_step && !acc_i.write;
   wire wr_step = do_step && acc_i.write;

   a_page_never_zero: assert property (
      rd_page != PG_ZERO && wr_page != PG_ZERO[8:0])
      else $error("page register holds zero");
   a_rd_edge_keep: assert property (
      rd_step && (rd_page == PG_EDS_LAST || rd_page == PG_MSB_LAST) && acc_i.inc
      |=> $stable(rd_page) && !res_o.ea_fix[15])
      else $error("read overflow at last page not held");
   a_rd_under_keep: assert property (
      rd_step && (rd_page == PG_RESET || rd_page == PG_LSW_FIRST) && !acc_i.inc
      |=> $stable(rd_page) && !res_o.ea_fix[15])
      else $error("read underflow at first page not held");
   a_psv_half_step: assert property (
      rd_step && rd_page == PG_LSW_LAST && acc_i.inc
      |=> rd_page == PG_MSB_FIRST && res_o.ea_fix[15] ##1 rd_page != PG_ZERO)
      else $error("program view overflow did not reach upper half");
   a_psv_half_back: assert property (
      rd_step && rd_page == PG_MSB_FIRST && !acc_i.inc
      |=> rd_page == PG_LSW_LAST && res_o.ea_fix[15])
      else $error("program view underflow did not return");
   a_wr_last_keep: assert property (
      wr_step && wr_page == PG_EDS_LAST[8:0] && acc_i.inc
      |=> $stable(wr_page) && !res_o.ea_fix[15])
      else $error("write overflow at last page not held");
   a_page_zero_trap: assert property (
      acc_i.valid && upper && pg_use == PG_ZERO |=> res_o.trap && trap_o)
      else $error("page zero access did not trap");
   a_ps_write_trap: assert property (
      sel_wr_page && hwdata_i[PG_PS_BIT] |=> trap_o && trap_psw && $stable(wr_page))
      else $error("write page to program space not trapped");
   a_low_base_page0: assert property (
      acc_i.valid && !ea_acc[15] |=> res_o.addr[23:16] == 8'h00 && !res_o.program_space_view)
      else $error("base address left page zero");
   a_page_map: assert property (
      acc_i.valid && upper |=> res_o.addr == {$past(pg_use[8:0]), $past(ea_acc[14:0])})
      else $error("page mapping wrong");
   a_stack_unpaged: assert property (
      acc_i.valid && acc_i.ptr_sp |=> res_o.addr == {8'h00, $past(ea_acc)})
      else $error("stack pointer access was paged");
   a_wrap_same_page: assert property (
      do_wrap |=> $stable(rd_page) && $stable(wr_page) && res_o.ea_fix[15])
      else $error("wrap mode changed the page");
   a_step_linear: assert property (
      rd_step && acc_i.inc && rd_page == 10'h005 |=> rd_page == 10'h006 ##1 rd_page != PG_ZERO)
      else $error("linear overflow did not increment");
endmodule

//--- verif/dspg_mem_model.sv
`timescale 1ns/1ns
module dspg_mem_model import dspg_pkg::*; (
   input wire logic clk_sys_i, // System clock.
   input wire dspg_stk_bus_t bus_i, // Stack memory access.
   input wire logic [15:0] look_i, // Address the bench inspects.
   output logic [15:0] look_o // Word held at that address.
);
   logic [15:0] mem [0:63];
   // Stack writes land in a small word array, enough for the low stack area.
   always_ff @(posedge clk_sys_i) begin
      if (bus_i.we) begin
         mem[bus_i.addr[6:1]] <= bus_i.wdata;
      end
   end
   // Unwritten words stay unknown, so a missed write can never pass.
   assign look_o = mem[look_i[6:1]];
endmodule

//--- verif/tb.sv
`timescale 1ns/1ns
module tb import dspg_pkg::*;;
   logic clk_sys_i = 1'b0, rst_b_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
   logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o, d;
   logic [1:0] htrans_i = 2'h0;
   logic hreadyout_o, hresp_o, trap_o, stk_busy_o;
   wire hready_i = hreadyout_o; // Single slave drives the bus ready.
   dspg_acc_req_t acc_i = '0;
   dspg_acc_res_t res_o;
   dspg_scmd_t stk_cmd_i = SC_NONE;
   dspg_stk_bus_t stk_bus_o;
   logic [15:0] stk_ptr_o, look = '0, look_o;
   int mismatches = 0, checked = 0, cycles = 0, traps = 0;
   dspg_top dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .hrdata_o(hrdata_o), .acc_i(acc_i), .res_o(res_o), .trap_o(trap_o),
      .stk_cmd_i(stk_cmd_i), .stk_wdata_i(16'habcd), .pc_i(23'h7a1234), .srl_i(8'h5c),
      .stk_bus_o(stk_bus_o), .stk_busy_o(stk_busy_o), .stk_ptr_o(stk_ptr_o));
   dspg_mem_model mem_u (.clk_sys_i(clk_sys_i), .bus_i(stk_bus_o), .look_i(look),
      .look_o(look_o));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, trap pulse count and a cycle ceiling well above the run length.
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      traps += (trap_o === 1'b1);
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // One AHB single transfer; read data is taken at the data-phase ready edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hsel_i <= 1'b0;
      hwdata_i <= wd;
      do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
      d = hrdata_o;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk("register", e, d);
      chk("response", {31'h0, HRESP_OKAY}, {31'h0, hresp_o});
   endtask
   task automatic rst_chk();
      rst_b_i <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      rdc(OFS_RD_PAGE, 32'h1);
      rdc(OFS_WR_PAGE, 32'h1);
      rdc(OFS_SP, 32'h1000);
   endtask
   // Loads the page, issues one access, then checks the result and the new page.
   // Pointer kind sp: bit 0 stack pointer, bit 1 active frame pointer, bit 2 post-modify.
   task automatic acc(input int w, input dspg_amode_t m, input int inc, sp,
      input logic [15:0] eo, en, input logic [9:0] pg, pe, input logic [15:0] ef,
      input logic [23:0] ad);
      bus(1'b1, (w != 0) ? OFS_WR_PAGE : OFS_RD_PAGE, {22'h0, pg});
      acc_i <= '{valid: 1'b1, write: w != 0, mode: m, pre_mod: m != AM_PLAIN && !sp[2],
         inc: inc != 0, ptr_sp: sp[0], ptr_fp: sp[1], frame_act: sp[1],
         ea_old: eo, ea_new: en};
      @(posedge clk_sys_i);
      acc_i <= '0;
      // The result stands until this edge, so it is read before the flops move.
      @(posedge clk_sys_i);
      if (m != AM_PLAIN) chk("ea fix", {16'h0, ef}, {16'h0, res_o.ea_fix});
      chk("result flags", 32'h2, {30'h0, res_o.valid, res_o.trap});
      chk("phys addr", {8'h0, ad}, {8'h0, res_o.addr});
      rdc(w ? OFS_WR_PAGE : OFS_RD_PAGE, {22'h0, pe});
   endtask
   task automatic stk(input dspg_scmd_t c, input logic [15:0] a, sp);
      stk_cmd_i <= c;
      @(posedge clk_sys_i);
      stk_cmd_i <= SC_NONE;
      // The access word stands for one cycle; it is read at the edge that ends it.
      @(posedge clk_sys_i);
      chk("stack addr", {16'h0, a}, {16'h0, stk_bus_o.addr});
      chk("stack dir", (c == SC_POP) ? 32'h1 : 32'h2, {30'h0, stk_bus_o.we, stk_bus_o.re});
      chk("stack busy", {31'h0, c == SC_CALL || c == SC_EXC}, {31'h0, stk_busy_o});
      @(posedge clk_sys_i);
      chk("stack ptr", {16'h0, sp}, {16'h0, stk_ptr_o});
   endtask
   task automatic lk(input logic [15:0] a, e);
      look <= a;
      @(posedge clk_sys_i);
      chk("stack word", {16'h0, e}, {16'h0, look_o});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence; a second reset at the end proves the reset values again.
   initial begin
      rst_chk();
      bus(1'b1, OFS_WR_PAGE, 32'h201);
      repeat (2) @(posedge clk_sys_i);
      chk("trap count", 32'h1, traps);
      rdc(OFS_WR_PAGE, 32'h1);
      rdc(OFS_STAT, 32'h2);
      acc(0, AM_MODIND, 1, 0, 16'hfffe, 16'h0000, 10'h1ff, 10'h1ff, 16'h0000, 24'h0);
      acc(0, AM_MODIND, 1, 0, 16'hfffe, 16'h0, 10'h2ff, 10'h300, 16'h8000, 24'h800000);
      rdc(OFS_STAT, 32'h6);
      acc(0, AM_MODIND, 1, 0, 16'hfffe, 16'h0000, 10'h3ff, 10'h3ff, 16'h0000, 24'h0);
      acc(0, AM_MODIND, 0, 0, 16'h8000, 16'h7ffe, 10'h1, 10'h1, 16'h7ffe, 24'h7ffe);
      acc(0, AM_MODIND, 0, 0, 16'h8000, 16'h7ffe, 10'h200, 10'h200, 16'h7ffe, 24'h7ffe);
      acc(0, AM_MODIND, 0, 0, 16'h8000, 16'h7ffe, 10'h300, 10'h2ff, 16'hfffe, 24'h7ffffe);
      acc(1, AM_MODIND, 1, 0, 16'hfffe, 16'h0000, 10'h1ff, 10'h1ff, 16'h0000, 24'h0);
      acc(0, AM_MODIND, 1, 0, 16'hfffe, 16'h0, 10'h5, 10'h6, 16'h8000, 24'h30000);
      acc(1, AM_MODIND, 0, 0, 16'h8000, 16'h7ffe, 10'h6, 10'h5, 16'hfffe, 24'h2fffe);
      acc(0, AM_WRAP, 1, 0, 16'hfffe, 16'h0000, 10'h5, 10'h5, 16'h8000, 24'h28000);
      acc(0, AM_MODIND, 1, 4, 16'hfffe, 16'h0, 10'h5, 10'h6, 16'h8000, 24'h2fffe);
      acc(0, AM_PLAIN, 1, 0, 16'hfffe, 16'h0000, 10'h5, 10'h5, 16'h0, 24'h2fffe);
      acc(0, AM_PLAIN, 0, 0, 16'h1234, 16'h1234, 10'h5, 10'h5, 16'h0, 24'h1234);
      acc(0, AM_PLAIN, 0, 0, 16'h8000, 16'h8000, 10'h2, 10'h2, 16'h0, 24'h10000);
      acc(0, AM_PLAIN, 0, 1, 16'h9000, 16'h9000, 10'h5, 10'h5, 16'h0, 24'h9000);
      acc(0, AM_PLAIN, 0, 2, 16'h9000, 16'h9000, 10'h5, 10'h5, 16'h0, 24'h9000);
      bus(1'b1, OFS_RD_PAGE, 32'h0);
      rdc(OFS_RD_PAGE, 32'h5);
      bus(1'b1, OFS_STAT, 32'h3);
      rdc(OFS_STAT, 32'h0);
      stk(SC_PUSH, 16'h1000, 16'h1002);
      stk(SC_CALL, 16'h1002, 16'h1006);
      stk(SC_EXC, 16'h1006, 16'h100a);
      stk(SC_POP, 16'h1008, 16'h1008);
      lk(16'h1000, 16'habcd);
      lk(16'h1002, 16'h1234);
      lk(16'h1004, 16'h007a);
      lk(16'h1008, 16'h5c7a);
      bus(1'b1, OFS_SP, 32'h2001);
      rdc(OFS_SP, 32'h2000);
      rst_chk();
      close_out();
   end
endmodule
